// ===== lar_pkg.sv
// Constants and helpers shared by the link mode resolver
package lar_pkg;

  // System clock rate in hertz
  localparam int unsigned CLK_HZ          = 10_000_000;

  // Ability bit positions, highest priority first
  localparam int unsigned ABIL_100_FULL   = 3;
  localparam int unsigned ABIL_100_HALF   = 2;
  localparam int unsigned ABIL_10_FULL    = 1;
  localparam int unsigned ABIL_10_HALF    = 0;
  localparam int unsigned ABIL_W          = 4;

  // All four abilities, sent in every advertisement
  localparam logic [3:0]  ABIL_ALL        = 4'hF;

  // Mode index fields: bit 1 is speed, bit 0 is duplex
  localparam int unsigned MODE_SPEED_BIT  = 1;
  localparam int unsigned MODE_DUPLEX_BIT = 0;

  // Wait for a partner advertisement before falling back
  localparam int unsigned NEG_WAIT_MS     = 50;
  localparam int unsigned NEG_WAIT_CYC    = NEG_WAIT_MS * (CLK_HZ / 1000);

  // Sensed speed must hold this long before it is trusted
  localparam int unsigned SENSE_STABLE_US  = 10;
  localparam int unsigned SENSE_STABLE_CYC = (SENSE_STABLE_US * (CLK_HZ / 1000) + 999) / 1000;

  // Reset values of the outputs
  localparam logic        LINK_RST        = 1'b0;
  localparam logic        SPEED_RST       = 1'b0;
  localparam logic        FULL_RST        = 1'b0;

  // Source of the current link mode
  typedef enum logic [1:0] {
    SRC_NONE   = 2'b00,
    SRC_NEG    = 2'b01,
    SRC_PAR    = 2'b10,
    SRC_FORCED = 2'b11
  } lar_src_t;

  // Resolver states
  typedef enum logic [2:0] {
    ST_ADV    = 3'b001,
    ST_NEG    = 3'b011,
    ST_PAR    = 3'b100,
    ST_FORCED = 3'b101
  } lar_state_t;

  // Highest priority common ability as a mode index
  function automatic logic [1:0] best_mode(input logic [3:0] common);
    logic [1:0] idx;
    idx = 2'h0;
    if (common[ABIL_100_FULL]) begin
      idx = 2'h3;
    end else if (common[ABIL_100_HALF]) begin
      idx = 2'h2;
    end else if (common[ABIL_10_FULL]) begin
      idx = 2'h1;
    end
    return idx;
  endfunction

endpackage

// ===== lar_speed_sense.sv
// Line speed sensing filter for one port
`timescale 1ns/1ps

module lar_speed_sense #(
  parameter int unsigned STABLE_CYC = lar_pkg::SENSE_STABLE_CYC
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_b_i,
  input  wire logic sense_valid_i,
  input  wire logic sense_100_i,
  output logic      sensed_valid_o,
  output logic      sensed_100_o
);

  localparam int unsigned CW = $clog2(STABLE_CYC + 1);

  // Refuse a zero settle time
  if (STABLE_CYC < 1) begin : g_chk
    $error("STABLE_CYC must be at least one");
  end

  logic [CW-1:0] cnt_reg;         // Cycles the raw inputs held still
  logic [CW-1:0] cnt_next;
  logic          last_100_reg;    // Raw speed seen last cycle
  logic          last_100_next;
  logic          valid_reg;       // Filtered presence
  logic          valid_next;
  logic          speed_reg;       // Filtered speed
  logic          speed_next;

  // Settle counter and filtered result
  always_comb begin
    cnt_next      = cnt_reg;
    last_100_next = sense_100_i;
    valid_next    = valid_reg;
    speed_next    = speed_reg;
    if (!sense_valid_i) begin
      // Loss of signal drops at once
      cnt_next   = '0;
      valid_next = 1'b0;
    end else if (sense_100_i != last_100_reg) begin
      // Speed changed, start settling again
      cnt_next   = '0;
      valid_next = 1'b0;
    end else if (cnt_reg == CW'(STABLE_CYC)) begin
      // Held long enough
      valid_next = 1'b1;
      speed_next = sense_100_i;
    end else begin
      cnt_next = cnt_reg + CW'(1);
    end
  end

  // Register the filter state
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_reg      <= '0;
      last_100_reg <= 1'b0;
      valid_reg    <= 1'b0;
      speed_reg    <= 1'b0;
    end else begin
      cnt_reg      <= cnt_next;
      last_100_reg <= last_100_next;
      valid_reg    <= valid_next;
      speed_reg    <= speed_next;
    end
  end

  assign sensed_valid_o = valid_reg;
  assign sensed_100_o   = speed_reg;

endmodule

// ===== lar_resolver.sv
// Link mode resolver for one twisted-pair port
//
// Operation
// - Rank modes: 100 before 10, full before half
// - Advertise all four abilities on configure or boot, unless forced
// - Run highest priority mode common to both
// - Speed and duplex by negotiation, link only if sensed speed agrees
// - Silent partner: sensed speed, half duplex
// - Forced mode sets software speed and duplex
`timescale 1ns/1ps

module lar_resolver #(
  parameter int unsigned NEG_WAIT_CYC = lar_pkg::NEG_WAIT_CYC,
  parameter int unsigned STABLE_CYC   = lar_pkg::SENSE_STABLE_CYC
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_b_i,
  input  wire logic       cfg_restart_i,
  input  wire logic       force_en_i,
  input  wire logic       force_speed_100_i,
  input  wire logic       force_full_i,
  input  wire logic       lp_valid_i,
  input  wire logic [3:0] lp_ability_i,
  input  wire logic       sense_valid_i,
  input  wire logic       sense_100_i,
  output logic            adv_valid_o,
  output logic [3:0]      adv_ability_o,
  output logic            link_up_o,
  output logic            speed_100_o,
  output logic            full_duplex_o,
  output logic [1:0]      mode_src_o
);

  localparam int unsigned TW = $clog2(NEG_WAIT_CYC + 1);

  // Refuse a zero wait
  if (NEG_WAIT_CYC < 1) begin : g_chk
    $error("NEG_WAIT_CYC must be at least one");
  end

  lar_pkg::lar_state_t state_reg;   // Resolver state
  lar_pkg::lar_state_t state_next;
  logic [TW-1:0]       timer_reg;   // Advertisement wait counter
  logic [TW-1:0]       timer_next;
  logic [1:0]          mode_reg;    // Resolved mode index
  logic [1:0]          mode_next;
  logic                adv_next;    // Output next values
  logic [3:0]          abil_next;
  logic                link_next;
  logic                speed_next;
  logic                full_next;
  logic [1:0]          src_next;
  logic                sensed_valid; // Filtered speed sense
  logic                sensed_100;
  logic [3:0]          common;       // Abilities both sides hold

  // Speed sensing filter
  lar_speed_sense #(
    .STABLE_CYC (STABLE_CYC)
  ) u_sense (
    .clk_sys_i      (clk_sys_i),
    .rst_b_i        (rst_b_i),
    .sense_valid_i  (sense_valid_i),
    .sense_100_i    (sense_100_i),
    .sensed_valid_o (sensed_valid),
    .sensed_100_o   (sensed_100)
  );

  // both ability sets
  // Intersect partner set with ours
  assign common = lp_ability_i & lar_pkg::ABIL_ALL;

  // Next state and output values
  always_comb begin
    state_next = state_reg;
    timer_next = timer_reg;
    mode_next  = mode_reg;
    unique case (state_reg)
      lar_pkg::ST_ADV: begin
        if (lp_valid_i && (common != 4'h0)) begin
          mode_next  = lar_pkg::best_mode(common);
          state_next = lar_pkg::ST_NEG;
        end else if (timer_reg == TW'(NEG_WAIT_CYC)) begin
          if (sensed_valid) begin
            state_next = lar_pkg::ST_PAR;
          end
        end else begin
          timer_next = timer_reg + TW'(1);
        end
      end
      lar_pkg::ST_NEG: begin
        // Lost line restarts the exchange only while the link is up
        if (link_up_o && !sensed_valid) begin
          state_next = lar_pkg::ST_ADV;
        end
      end
      lar_pkg::ST_PAR: begin
        if (lp_valid_i && (common != 4'h0)) begin
          // Late advertisement wins over fallback
          mode_next  = lar_pkg::best_mode(common);
          state_next = lar_pkg::ST_NEG;
        end else if (!sensed_valid) begin
          state_next = lar_pkg::ST_ADV;
        end
      end
      lar_pkg::ST_FORCED: begin
        if (!force_en_i) begin
          state_next = lar_pkg::ST_ADV;
        end
      end
      default: begin
        state_next = lar_pkg::ST_ADV;
      end
    endcase
    if (cfg_restart_i && (state_next != lar_pkg::ST_FORCED)) begin
      state_next = lar_pkg::ST_ADV;
    end
    if (force_en_i) begin
      state_next = lar_pkg::ST_FORCED;
    end
    if (state_next == lar_pkg::ST_ADV && state_reg != lar_pkg::ST_ADV) begin
      timer_next = '0;
    end
    if (cfg_restart_i) begin
      timer_next = '0;
    end
    // Outputs follow the next state
    adv_next   = 1'b0;
    abil_next  = 4'h0;
    link_next  = 1'b0;
    speed_next = 1'b0;
    full_next  = 1'b0;
    src_next   = lar_pkg::SRC_NONE;
    unique case (state_next)
      lar_pkg::ST_ADV: begin
        adv_next  = 1'b1;
        abil_next = lar_pkg::ABIL_ALL;
      end
      lar_pkg::ST_NEG: begin
        adv_next   = 1'b1;
        abil_next  = lar_pkg::ABIL_ALL;
        src_next   = lar_pkg::SRC_NEG;
        speed_next = mode_next[lar_pkg::MODE_SPEED_BIT];
        full_next  = mode_next[lar_pkg::MODE_DUPLEX_BIT];
        link_next  = sensed_valid && (sensed_100 == mode_next[lar_pkg::MODE_SPEED_BIT]);
      end
      lar_pkg::ST_PAR: begin
        adv_next   = 1'b1;
        abil_next  = lar_pkg::ABIL_ALL;
        src_next   = lar_pkg::SRC_PAR;
        speed_next = sensed_100;
        full_next  = 1'b0;
        link_next  = sensed_valid;
      end
      lar_pkg::ST_FORCED: begin
        src_next   = lar_pkg::SRC_FORCED;
        speed_next = force_speed_100_i;
        full_next  = force_full_i;
        link_next  = 1'b1;
      end
      default: begin
        adv_next = 1'b0;
      end
    endcase
  end

  // Register state and outputs
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg     <= lar_pkg::ST_ADV;
      timer_reg     <= '0;
      mode_reg      <= 2'h0;
      adv_valid_o   <= 1'b0;
      adv_ability_o <= 4'h0;
      link_up_o     <= lar_pkg::LINK_RST;
      speed_100_o   <= lar_pkg::SPEED_RST;
      full_duplex_o <= lar_pkg::FULL_RST;
      mode_src_o    <= lar_pkg::SRC_NONE;
    end else begin
      state_reg     <= state_next;
      timer_reg     <= timer_next;
      mode_reg      <= mode_next;
      adv_valid_o   <= adv_next;
      adv_ability_o <= abil_next;
      link_up_o     <= link_next;
      speed_100_o   <= speed_next;
      full_duplex_o <= full_next;
      mode_src_o    <= src_next;
    end
  end

  logic [1:0] exp_mode_reg;   // Best mode of the last accepted partner set
  logic [1:0] exp_mode_next;

  // Track the partner set that negotiation accepted
  always_comb begin
    exp_mode_next = exp_mode_reg;
    if (lp_valid_i && (common != 4'h0) && !force_en_i && !cfg_restart_i
        && (state_reg == lar_pkg::ST_ADV || state_reg == lar_pkg::ST_PAR)) begin
      exp_mode_next = lar_pkg::best_mode(common);
    end
  end

  // Register the tracked mode
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      exp_mode_reg <= 2'h0;
    end else begin
      exp_mode_reg <= exp_mode_next;
    end
  end

  adv_all_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    adv_valid_o |-> adv_ability_o == lar_pkg::ABIL_ALL)
    else $error("advertisement lacks an ability");

  restart_adv_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (cfg_restart_i && !force_en_i) |=> (adv_valid_o && mode_src_o == lar_pkg::SRC_NONE))
    else $error("restart did not advertise");

  prio_pick_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (mode_src_o == lar_pkg::SRC_NEG) |-> ({speed_100_o, full_duplex_o} == exp_mode_reg))
    else $error("resolved mode is not the best common one");

  sense_speed_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (link_up_o && mode_src_o != lar_pkg::SRC_FORCED) |-> speed_100_o == $past(sensed_100))
    else $error("link speed differs from sensed speed");

  par_half_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (mode_src_o == lar_pkg::SRC_PAR) |-> (!full_duplex_o && adv_valid_o))
    else $error("fallback link not half duplex");

  force_apply_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    force_en_i |=> (mode_src_o == lar_pkg::SRC_FORCED && link_up_o
                    && speed_100_o == $past(force_speed_100_i) && full_duplex_o == $past(force_full_i)))
    else $error("forced mode not applied");

  force_quiet_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (mode_src_o == lar_pkg::SRC_FORCED) |-> !adv_valid_o)
    else $error("advertising while forced");

  force_resume_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $fell(force_en_i) |=> (adv_valid_o && !link_up_o))
    else $error("advertising did not resume");

endmodule

// ===== lar_link_partner.sv
// Far end model: answers the port's advertisement with its own abilities
`timescale 1ns/1ps

module lar_link_partner (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_b_i,
  input  wire logic       adv_valid_i,
  input  wire logic [3:0] adv_ability_i,
  input  wire logic       arm_i,
  input  wire logic [3:0] abil_i,
  input  wire logic [2:0] dly_i,
  output logic            lp_valid_o,
  output logic [3:0]      lp_ability_o
);
  logic       armed_reg;  // Answer pending
  logic [2:0] wait_reg;   // Cycles left before the answer

  // Partner drives after the falling edge; the word toggles when not sent
  // returns own abilities
  always @(negedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      armed_reg    <= 1'b0;
      wait_reg     <= 3'h0;
      lp_valid_o   <= 1'b0;
      lp_ability_o <= 4'h0;
    end else begin
      lp_valid_o   <= 1'b0;
      lp_ability_o <= ~lp_ability_o;
      if (arm_i) begin
        armed_reg <= 1'b1;
        wait_reg  <= dly_i;
      end else if (armed_reg && adv_valid_i && adv_ability_i == 4'hF) begin
        // Answer only to a full advertisement
        if (wait_reg == 3'h0) begin
          lp_valid_o   <= 1'b1;
          lp_ability_o <= abil_i;
          armed_reg    <= 1'b0;
        end else begin
          wait_reg <= wait_reg - 3'h1;
        end
      end
    end
  end
endmodule

// ===== testbench.sv
// Self-checking bench for the link mode resolver
`timescale 1ns/1ps

module testbench;
  localparam int NW = 20;  // Short partner wait
  localparam int SC = 4;   // Short sensing settle

  logic       clk_sys_i, rst_b_i, cfg_restart_i, force_en_i;
  logic       force_speed_100_i, force_full_i, lp_valid_i;
  logic [3:0] lp_ability_i, abil;
  logic       sense_valid_i, sense_100_i, arm;
  logic [2:0] dly;
  logic       adv_valid_o, link_up_o, speed_100_o, full_duplex_o;
  logic [3:0] adv_ability_o;
  logic [1:0] mode_src_o;
  int         err_count, cmp_count, cyc;

  lar_resolver #(.NEG_WAIT_CYC(NW), .STABLE_CYC(SC)) u_lar_resolver (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .cfg_restart_i(cfg_restart_i),
    .force_en_i(force_en_i), .force_speed_100_i(force_speed_100_i),
    .force_full_i(force_full_i), .lp_valid_i(lp_valid_i), .lp_ability_i(lp_ability_i),
    .sense_valid_i(sense_valid_i), .sense_100_i(sense_100_i), .adv_valid_o(adv_valid_o),
    .adv_ability_o(adv_ability_o), .link_up_o(link_up_o), .speed_100_o(speed_100_o),
    .full_duplex_o(full_duplex_o), .mode_src_o(mode_src_o));

  lar_link_partner u_lar_link_partner (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .adv_valid_i(adv_valid_o),
    .adv_ability_i(adv_ability_o), .arm_i(arm), .abil_i(abil), .dly_i(dly),
    .lp_valid_o(lp_valid_i), .lp_ability_o(lp_ability_i));

  // Free running clock
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  // Hang guard
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      $display("ERROR %0t: timeout", $time);
      test_done();
    end
  end

  // All outputs packed for one compare
  function automatic logic [9:0] obs();
    return {adv_valid_o, adv_ability_o, link_up_o, speed_100_o, full_duplex_o, mode_src_o};
  endfunction

  // Reference: best common mode, link only when sensing agrees
  function automatic logic [9:0] exp_neg(int lp, logic s);
    int   b;
    logic spd;
    b = 0;
    for (int p = 0; p < 4; p++) if (lp[p]) b = p;
    spd = (b >= 2);
    return {1'b1, 4'hF, spd == s, spd, logic'(b % 2 == 1), 2'h1};
  endfunction

  // Compare and count
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Set sensing, let it settle, restart advertising
  task automatic restart(input logic s, input logic go);
    @(negedge clk_sys_i);
    sense_100_i <= s;
    repeat (SC + 4) @(negedge clk_sys_i);
    cfg_restart_i <= 1'b1;
    arm           <= go;
    dly           <= 3'($urandom % 8);
    @(negedge clk_sys_i);
    cfg_restart_i <= 1'b0;
    arm           <= 1'b0;
  endtask

  // Negotiate with a partner offering lp
  task automatic neg(input int lp, input logic s);
    abil <= 4'(lp);
    restart(s, 1'b1);
    for (int n = 0; n < 40 && lp_valid_i !== 1'b1; n++) @(negedge clk_sys_i);
    chk(obs(), exp_neg(lp, s));
  endtask

  // Arm the partner without a restart and wait for its answer
  task automatic answer(input int lp);
    abil <= 4'(lp);
    arm  <= 1'b1;
    dly  <= 3'($urandom % 8);
    @(negedge clk_sys_i);
    arm  <= 1'b0;
    for (int n = 0; n < 40 && lp_valid_i !== 1'b1; n++) @(negedge clk_sys_i);
  endtask

  task automatic test_done();
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {rst_b_i, cfg_restart_i, force_en_i, force_speed_100_i, force_full_i} = 5'h0;
    {sense_100_i, arm, abil, dly} = 9'h0;
    sense_valid_i = 1'b1;
    void'($urandom(34482));
    repeat (16) @(negedge clk_sys_i);
    rst_b_i <= 1'b1;
    @(negedge clk_sys_i);
    chk(obs(), 10'h3E0);
    // Every non-empty partner set, both sensed speeds
    for (int lp = 1; lp < 16; lp++) begin
      neg(lp, lp[0]);
      neg(lp, ~lp[0]);
    end
    repeat (8) neg($urandom_range(15, 1), 1'($urandom % 2));
    // A second answer while negotiated is refused
    neg(4'h1, 1'b0);
    answer(4'hF);
    chk(obs(), exp_neg(4'h1, 1'b0));
    // Silent partner falls back to half duplex
    for (int s = 0; s < 2; s++) begin
      restart(1'(s), 1'b0);
      repeat (NW + 6) @(negedge clk_sys_i);
      chk(obs(), {1'b1, 4'hF, 1'b1, 1'(s), 1'b0, 2'h2});
      // Line loss: advertise again, no fallback without a sensed speed
      sense_valid_i <= 1'b0;
      repeat (NW + 6) @(negedge clk_sys_i);
      chk(obs(), 10'h3E0);
      // Line back: fallback once sensing settles
      sense_valid_i <= 1'b1;
      repeat (SC + 4) @(negedge clk_sys_i);
      chk(obs(), {1'b1, 4'hF, 1'b1, 1'(s), 1'b0, 2'h2});
      // Late answer moves the fallback link to negotiation
      answer($urandom_range(15, 1));
      chk(obs(), exp_neg(abil, 1'(s)));
    end
    // Forced modes ignore restart and stop advertising
    for (int i = 0; i < 4; i++) begin
      force_en_i        <= 1'b1;
      force_speed_100_i <= i[1];
      force_full_i      <= i[0];
      cfg_restart_i     <= 1'b1;
      repeat (3) @(negedge clk_sys_i);
      chk(obs(), {1'b0, 4'h0, 1'b1, i[1], i[0], 2'h3});
      force_en_i    <= 1'b0;
      cfg_restart_i <= 1'b0;
      @(negedge clk_sys_i);
      chk(obs(), 10'h3E0);
    end
    // Second reset gives a fresh boot advertisement
    neg(4'hF, 1'b1);
    rst_b_i <= 1'b0;
    repeat (2) @(negedge clk_sys_i);
    rst_b_i <= 1'b1;
    @(negedge clk_sys_i);
    chk(obs(), 10'h3E0);
    test_done();
  end
endmodule
